// ### core/power_down_instruction.sv
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
// Notes on behaviour
// - power-down clears powerdown_flag to zero
// - power-down sets timeout_flag to one
// - power-down clears watchdog counter and postscaler
// - then halt, stop oscillator, no fetches
// - one-word single-cycle opcode, upper twelve zero
module power_down_instruction
    import powerdown_pkg::*;
#(
    parameter int RESTART_COUNT = RESTART_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic wake_request,
    output logic fetch_enable,
    output logic osc_stop,
    output logic halted,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic powerdown_executed
);

    import powerdown_pkg::*;

    function automatic logic is_powerdown(input logic [15:0] word);
        begin
            is_powerdown = ((word & OPCODE_PREFIX_MASK) == OPCODE_PREFIX_VALUE)
                && (word == OPCODE_POWERDOWN);
        end
    endfunction : is_powerdown

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
        begin
            addr_hit = (addr == offset);
        end
    endfunction : addr_hit

    core_state_t state;
    core_state_t next_state;

    logic wdog_enable;
    logic [2:0] post_sel;
    logic [15:0] exec_count;
    logic [7:0] restart_timer;
    logic [7:0] next_restart_timer;

    logic [WATCHDOG_WIDTH-1:0] wdog_count;
    logic [POSTSCALER_WIDTH-1:0] wdog_post;
    logic wdog_overflow;
    logic wdog_clear;

    logic access;
    logic write_access;
    logic control_write;
    logic read_setup;
    logic hit_control;
    logic hit_status;
    logic hit_watchdog;
    logic hit_count;
    logic hit_any;
    logic [31:0] read_mux;
    logic [31:0] control_value;
    logic [31:0] status_value;
    logic [31:0] watchdog_value;

    logic decode_hit;
    logic execute_powerdown;
    logic wake_event;
    logic next_timeout_flag;
    logic next_powerdown_flag;
    logic next_halted;
    logic next_osc_stop;
    logic next_fetch_enable;
    logic [15:0] next_exec_count;
    logic [7:0] restart_load;

    // instruction decode
    assign decode_hit = instr_valid && is_powerdown(instr_word);
    assign execute_powerdown = decode_hit && (state == CORE_RUN) && fetch_enable;
    assign wake_event = wake_request || wdog_overflow;
    assign wdog_clear = execute_powerdown;

    // apb decode
    assign access = psel && penable;
    assign write_access = access && pwrite;
    assign control_write = write_access && hit_control;
    assign read_setup = psel && !penable && !pwrite;
    assign hit_control = addr_hit(paddr, OFFSET_CONTROL);
    assign hit_status = addr_hit(paddr, OFFSET_STATUS);
    assign hit_watchdog = addr_hit(paddr, OFFSET_WATCHDOG);
    assign hit_count = addr_hit(paddr, OFFSET_COUNT);
    assign hit_any = hit_control || hit_status || hit_watchdog || hit_count;
    assign pready = 1'b1;
    assign pslverr = access && (!hit_any || (pwrite && !hit_control));

    assign control_value = {28'h0000000, post_sel, wdog_enable};
    assign status_value = {28'h0000000, osc_stop, halted, powerdown_flag, timeout_flag};
    assign watchdog_value = {16'h0000, wdog_post, wdog_count};
    assign read_mux = hit_control ? control_value
        : hit_status ? status_value
        : hit_watchdog ? watchdog_value
        : hit_count ? {16'h0000, exec_count}
        : 32'h00000000;

    // core sequencing
    assign restart_load = 8'(RESTART_COUNT);

    always_comb
    begin
        next_state = state;
        next_restart_timer = restart_timer;
        case (state)
            CORE_RUN:
            begin
                if (execute_powerdown)
                begin
                    next_state = CORE_HALT;
                end
            end
            CORE_HALT:
            begin
                if (wake_event)
                begin
                    next_state = CORE_RESTART;
                    next_restart_timer = restart_load;
                end
            end
            CORE_RESTART:
            begin
                if (restart_timer <= 8'h01)
                begin
                    next_state = CORE_RUN;
                    next_restart_timer = 8'h00;
                end
                else
                begin
                    next_restart_timer = restart_timer - 8'h01;
                end
            end
            default:
            begin
                next_state = CORE_RUN;
                next_restart_timer = 8'h00;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= CORE_RUN;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            restart_timer <= 8'h00;
        end
        else
        begin
            restart_timer <= next_restart_timer;
        end
    end

    // halt and oscillator outputs
    assign next_halted = (next_state != CORE_RUN);
    assign next_osc_stop = (next_state == CORE_HALT);
    assign next_fetch_enable = (next_state == CORE_RUN);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            halted <= 1'b0;
            osc_stop <= 1'b0;
            fetch_enable <= 1'b1;
        end
        else
        begin
            halted <= next_halted;
            osc_stop <= next_osc_stop;
            fetch_enable <= next_fetch_enable;
        end
    end

    // status flags, power-down wins over watchdog wake
    assign next_timeout_flag = execute_powerdown ? 1'b1
        : wdog_overflow ? 1'b0
        : timeout_flag;
    assign next_powerdown_flag = execute_powerdown ? 1'b0 : powerdown_flag;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timeout_flag <= TIMEOUT_FLAG_RESET;
        end
        else
        begin
            timeout_flag <= next_timeout_flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            powerdown_flag <= POWERDOWN_FLAG_RESET;
        end
        else
        begin
            powerdown_flag <= next_powerdown_flag;
        end
    end

    // execution pulse and counter
    assign next_exec_count = execute_powerdown ? exec_count + 16'h0001 : exec_count;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            powerdown_executed <= 1'b0;
        end
        else
        begin
            powerdown_executed <= execute_powerdown;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exec_count <= COUNT_RESET;
        end
        else
        begin
            exec_count <= next_exec_count;
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdog_enable <= CONTROL_ENABLE_RESET;
            post_sel <= CONTROL_POST_SEL_RESET;
        end
        else if (control_write)
        begin
            wdog_enable <= pwdata[CTRL_WDOG_ENABLE_BIT];
            post_sel <= pwdata[CTRL_POST_SEL_LSB +: CTRL_POST_SEL_WIDTH];
        end
    end

    // read data register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else if (read_setup)
        begin
            prdata <= read_mux;
        end
    end

    watchdog_counter #(
        .COUNT_WIDTH(WATCHDOG_WIDTH),
        .POST_WIDTH(POSTSCALER_WIDTH)
    ) u_watchdog (
        .pclk(pclk),
        .presetn(presetn),
        .enable(wdog_enable),
        .clear(wdog_clear),
        .post_sel(post_sel),
        .count(wdog_count),
        .postscaler(wdog_post),
        .overflow(wdog_overflow)
    );

endmodule : power_down_instruction

// ### core/powerdown_pkg.sv
package powerdown_pkg;

    // instruction word layout
    localparam int INSTR_WIDTH = 16;
    localparam logic [15:0] OPCODE_POWERDOWN = 16'h0003;
    localparam logic [15:0] OPCODE_PREFIX_MASK = 16'hFFF0;
    localparam logic [15:0] OPCODE_PREFIX_VALUE = 16'h0000;

    // watchdog widths and clear values
    localparam int WATCHDOG_WIDTH = 8;
    localparam int POSTSCALER_WIDTH = 8;
    localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
    localparam logic [7:0] POSTSCALER_CLEAR = 8'h00;

    // register byte offsets
    localparam logic [7:0] OFFSET_CONTROL = 8'h00;
    localparam logic [7:0] OFFSET_STATUS = 8'h04;
    localparam logic [7:0] OFFSET_WATCHDOG = 8'h08;
    localparam logic [7:0] OFFSET_COUNT = 8'h0C;

    // control field positions
    localparam int CTRL_WDOG_ENABLE_BIT = 0;
    localparam int CTRL_POST_SEL_LSB = 1;
    localparam int CTRL_POST_SEL_WIDTH = 3;

    // status field positions
    localparam int STAT_TIMEOUT_BIT = 0;
    localparam int STAT_POWERDOWN_BIT = 1;
    localparam int STAT_HALTED_BIT = 2;
    localparam int STAT_OSC_STOPPED_BIT = 3;

    // watchdog register field positions
    localparam int WDOG_COUNT_LSB = 0;
    localparam int WDOG_POST_LSB = 8;

    // reset values
    localparam logic CONTROL_ENABLE_RESET = 1'b0;
    localparam logic [2:0] CONTROL_POST_SEL_RESET = 3'h0;
    localparam logic TIMEOUT_FLAG_RESET = 1'b1;
    localparam logic POWERDOWN_FLAG_RESET = 1'b1;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // oscillator restart time
    localparam int CLOCK_PERIOD_PS = 5000;
    localparam int RESTART_TIME_NS = 20;
    localparam int RESTART_CYCLES = (RESTART_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

    typedef enum logic [1:0]
    {
        CORE_RUN = 2'b00,
        CORE_HALT = 2'b01,
        CORE_RESTART = 2'b11
    } core_state_t;

endpackage : powerdown_pkg

// ### core/watchdog_counter.sv
`timescale 1ns/100ps
module watchdog_counter
    import powerdown_pkg::*;
#(
    parameter int COUNT_WIDTH = WATCHDOG_WIDTH,
    parameter int POST_WIDTH = POSTSCALER_WIDTH
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic clear,
    input wire logic [2:0] post_sel,
    output logic [COUNT_WIDTH-1:0] count,
    output logic [POST_WIDTH-1:0] postscaler,
    output logic overflow
);

    logic [POST_WIDTH-1:0] next_postscaler;
    logic post_tick;
    logic count_wrap;

    // postscaler ticks when the selected bit pattern is all ones
    assign post_tick = (postscaler & POST_WIDTH'((1 << post_sel) - 1)) == POST_WIDTH'((1 << post_sel) - 1);
    assign next_postscaler = post_tick ? '0 : postscaler + POST_WIDTH'(1);
    assign count_wrap = post_tick && (count == {COUNT_WIDTH{1'b1}});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= '0;
            postscaler <= '0;
            overflow <= 1'b0;
        end
        else if (clear)
        begin
            count <= COUNT_WIDTH'(WATCHDOG_CLEAR);
            postscaler <= POST_WIDTH'(POSTSCALER_CLEAR);
            overflow <= 1'b0;
        end
        else if (enable)
        begin
            postscaler <= next_postscaler;
            count <= post_tick ? count + COUNT_WIDTH'(1) : count;
            overflow <= count_wrap;
        end
        else
        begin
            overflow <= 1'b0;
        end
    end

endmodule : watchdog_counter

// ### sim/pd_monitor.sv
`timescale 1ns/100ps
module pd_monitor
    import powerdown_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic fetch_enable,
    input wire logic osc_stop,
    input wire logic halted,
    input wire logic timeout_flag,
    input wire logic powerdown_flag,
    input wire logic powerdown_executed
);
    wire logic take;
    wire logic other;
    assign take = instr_valid && (instr_word == OPCODE_POWERDOWN) && fetch_enable;
    assign other = instr_valid && (instr_word != OPCODE_POWERDOWN);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence halt_s;
        halted && osc_stop && !fetch_enable;
    endsequence
    sequence pulse_s;
        powerdown_executed ##1 !powerdown_executed;
    endsequence
    pd_clear_a:
        assert property (take |=> !powerdown_flag) else $error("powerdown flag not cleared");
    pd_hold_a:
        assert property (!powerdown_flag |=> !powerdown_flag) else $error("powerdown flag came back");
    to_set_a:
        assert property (take |=> timeout_flag) else $error("timeout flag not set");
    halt_enter_a:
        assert property (take |=> halt_s ##1 !fetch_enable) else $error("core did not halt");
    pulse_once_a:
        assert property (take |=> pulse_s) else $error("executed pulse not one cycle");
    pulse_cause_a:
        assert property (powerdown_executed |-> $past(take)) else $error("pulse without opcode");
    other_ignored_a:
        assert property (other |=> !powerdown_executed) else $error("other opcode taken");
endmodule : pd_monitor

bind power_down_instruction pd_monitor mon (.pclk, .presetn, .instr_valid, .instr_word, .fetch_enable,
    .osc_stop, .halted, .timeout_flag, .powerdown_flag, .powerdown_executed);

// ### sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import powerdown_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic instr_valid = 0;
    logic wake_request = 0;
    logic [15:0] instr_word = 16'h0000;
    logic [31:0] prdata;
    logic pready, pslverr, fetch_enable, osc_stop, halted;
    logic timeout_flag, powerdown_flag, powerdown_executed;
    logic [31:0] q[$];
    logic [15:0] w;
    int n_fail = 0;
    int check_count = 0;
    int i;
    always #2.5 pclk = ~pclk;
    power_down_instruction #(.RESTART_COUNT(2)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr_word, .wake_request, .fetch_enable,
        .osc_stop, .halted, .timeout_flag, .powerdown_flag, .powerdown_executed);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // read data checked against oldest note
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk(prdata, q.pop_front());

    // for reads d is the expected data
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        int k;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr)
            q.push_back(d);
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            n_fail++;
            conclude();
        end
        chk(32'(pslverr), 32'(err));
        psel <= 0;
        penable <= 0;
    endtask : apb

    task automatic instr(input logic [15:0] v);
        @(posedge pclk);
        instr_valid <= 1;
        instr_word <= v;
        @(posedge pclk);
        instr_valid <= 0;
        #1;
    endtask : instr

    task automatic wake();
        @(posedge pclk);
        wake_request <= 1;
        @(posedge pclk);
        wake_request <= 0;
        #1;
        chk(32'(osc_stop), 32'h0);
        i = 0;
        while (fetch_enable !== 1'b1 && i < 20)
        begin
            @(posedge pclk);
            #1;
            i++;
        end
        if (i >= 20)
        begin
            n_fail++;
            conclude();
        end
        chk(32'(i), 32'h2);
    endtask : wake

    initial
    begin
        void'($urandom(82));
        repeat (10) @(posedge pclk);
        presetn <= 1;
        apb(0, OFFSET_STATUS, 32'h3, 0);
        apb(0, 8'h10, 32'h0, 1);
        apb(1, OFFSET_STATUS, 32'hF, 1);
        apb(0, OFFSET_COUNT, 32'h0, 0);
        for (int k = 0; k < 24; k++)
        begin
            w = (k < 16) ? 16'(k) : 16'($urandom);
            if (w == OPCODE_POWERDOWN)
                w = 16'h0002;
            instr(w);
            chk(32'({powerdown_executed, fetch_enable}), 32'h1);
        end
        apb(1, OFFSET_CONTROL, 32'h7, 0);
        repeat (20) @(posedge pclk);
        apb(1, OFFSET_CONTROL, 32'h0, 0);
        apb(0, OFFSET_WATCHDOG, 32'h0702, 0);
        instr(OPCODE_POWERDOWN);
        chk(32'({halted, osc_stop, fetch_enable, powerdown_flag, timeout_flag}), 32'h19);
        chk(32'(powerdown_executed), 32'h1);
        @(posedge pclk);
        #1;
        chk(32'(powerdown_executed), 32'h0);
        apb(0, OFFSET_WATCHDOG, 32'h0, 0);
        apb(0, OFFSET_STATUS, 32'hD, 0);
        instr(OPCODE_POWERDOWN);
        apb(0, OFFSET_COUNT, 32'h1, 0);
        wake();
        apb(0, OFFSET_STATUS, 32'h1, 0);
        instr(OPCODE_POWERDOWN);
        apb(0, OFFSET_COUNT, 32'h2, 0);
        apb(0, OFFSET_STATUS, 32'hD, 0);
        wake();
        presetn <= 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, OFFSET_STATUS, 32'h3, 0);
        apb(0, OFFSET_COUNT, 32'h0, 0);
        apb(1, OFFSET_CONTROL, 32'h1, 0);
        i = 0;
        while (timeout_flag !== 1'b0 && i < 300)
        begin
            @(posedge pclk);
            #1;
            i++;
        end
        if (i >= 300)
        begin
            n_fail++;
            conclude();
        end
        apb(0, OFFSET_STATUS, 32'h2, 0);
        instr(OPCODE_POWERDOWN);
        chk(32'({powerdown_flag, timeout_flag}), 32'h1);
        i = 0;
        while (fetch_enable !== 1'b1 && i < 300)
        begin
            @(posedge pclk);
            #1;
            i++;
        end
        if (i >= 300)
        begin
            n_fail++;
            conclude();
        end
        apb(0, OFFSET_STATUS, 32'h0, 0);
        conclude();
    end
endmodule : tb_top
